// *** include/pdl_pkg.sv ***
`default_nettype none
package pdl_pkg;
    // ------------------------------------------------------------
    // Widths and lengths
    // ------------------------------------------------------------
    localparam int DATA_W = 10;
    localparam int LEN_W = 11;
    localparam logic [10:0] LEN_MAX = 11'h04FF;
    localparam int RAM_DEPTH = 1280;
    localparam int TOTAL_OFFSET = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_STAGES = 3;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LENGTH = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_HOLD_BIT = 0;
    localparam int CTRL_OFF_BIT = 1;
    localparam int STAT_MODE_BIT = 0;
    localparam int STAT_HOLD_BIT = 1;
    localparam int STAT_EDGE_BIT = 2;
    localparam int STAT_PEND_BIT = 3;
    localparam int STAT_FILL_LSB = 8;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [10:0] LENGTH_RESET = 11'h0000;

    // ------------------------------------------------------------
    // Control pin group
    // ------------------------------------------------------------
    typedef struct packed {
        logic source_select;
        logic edge_select;
        logic clock_hold;
        logic length_load_n;
        logic [LEN_W-1:0] length_in;
    } pdl_ctl_t;

    localparam int CTL_W = $bits(pdl_ctl_t);
endpackage
`default_nettype wire

// *** rtl/pdl_delay_line.sv ***
`default_nettype none

// ------------------------------------------------------------
// Output stream buffer
// ------------------------------------------------------------
module pdl_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [$clog2(DEPTH+1)-1:0] count_o
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic push;
    logic pop;

    assign in_ready_o = (count_r != CW'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_r];
    assign count_o = count_r;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= bump(wr_ptr_r);
            end
            if (pop) begin
                rd_ptr_r <= bump(rd_ptr_r);
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    a_fifo_no_over: assert property (@(posedge clk_i) disable iff (rst_i)
        count_r <= CW'(DEPTH))
        else $error("fifo count beyond depth");
endmodule // pdl_fifo

// Notes on behaviour
// RQ1: Delay mode gives a pipeline of 2 to 1281 active edges.
// RQ2: Recirculate mode feeds the output word back into the line input.
// RQ3: Low length_load_n captures length_in at the next active edge.
// RQ4: Total delay equals loaded length plus two, lengths 0 to 1279.
// RQ5: Input register, length-deep memory, output register; length 0 skips memory.
// RQ6: Data words are ten bits wide on input and output.
// RQ7: A captured word reaches the output after N active edges in total.
// RQ8: With source_select low a new input word is taken every active edge; the code ignores active edges that arrive while the stream buffer is full.
// RQ9: source_select may change while running, synchronous to the active edge.
// RQ10: edge_select low uses falling edges, high uses rising edges.
// RQ11: clock_hold high freezes all operations and stored data.
// RQ12: clock_hold sampled at one active edge acts from the next one.
// RQ13: Low output enable drives data_out, high releases the drivers.
// RQ14: Output enable touches only the drivers, never the data movement.
// RQ15: Controlling logic never loads a length above 1279.
// RQ16: length_in is unsigned, bit ten most significant, bit zero least.
// RQ17: source_select sampled at one edge picks the source at the next.
// RQ18: Delay memory and line contents are undefined until filled.
module pdl_delay_line #(
    parameter int DEPTH = pdl_pkg::RAM_DEPTH,
    parameter int FDEPTH = pdl_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic dev_clk_i,
    input wire logic [pdl_pkg::DATA_W-1:0] data_in_i,
    input wire pdl_pkg::pdl_ctl_t ctl_i,
    input wire logic output_enable_n_i,
    output logic [pdl_pkg::DATA_W-1:0] data_out_o,
    output logic [pdl_pkg::DATA_W-1:0] data_out_oe_o,
    output logic [pdl_pkg::DATA_W-1:0] stream_data_o,
    output logic stream_valid_o,
    input wire logic stream_ready_i
);
    import pdl_pkg::*;

    localparam int PW = 2 + DATA_W + CTL_W;
    localparam int FCW = $clog2(FDEPTH+1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [PW-1:0] pins;
    logic [PW-1:0] s1_r;
    logic [PW-1:0] s2_r;
    logic [PW-1:0] s3_r;
    logic [PW-1:0] filt_r;
    logic dclk_d_r;
    logic dclk;
    logic oe_n;
    logic [DATA_W-1:0] din;
    pdl_ctl_t ctl;

    assign pins = {dev_clk_i, output_enable_n_i, data_in_i, ctl_i};
    assign dclk = filt_r[PW-1];
    assign oe_n = filt_r[PW-2];
    assign din = filt_r[CTL_W +: DATA_W];
    assign ctl = pdl_ctl_t'(filt_r[CTL_W-1:0]);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A bit only changes once the last two stages agree
    for (genvar g = 0; g < PW; g++) begin : g_filt
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                filt_r[g] <= 1'b1;
            end else if (s2_r[g] == s3_r[g]) begin
                filt_r[g] <= s3_r[g];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dclk_d_r <= 1'b1;
        end else begin
            dclk_d_r <= dclk;
        end
    end

    // ------------------------------------------------------------
    // Active edge and advance
    // ------------------------------------------------------------
    logic tick;
    logic take;
    logic adv;
    logic hold_r;
    logic sw_hold_r;
    logic sw_off_r;
    logic fifo_in_ready;

    assign tick = (dclk != dclk_d_r) && (dclk == ctl.edge_select); // [RQ10]
    assign take = tick && fifo_in_ready;
    assign adv = take && !hold_r && !sw_hold_r; // [RQ11]

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_r <= 1'b0;
        end else if (take) begin
            hold_r <= ctl.clock_hold; // [RQ12]
        end
    end

    // ------------------------------------------------------------
    // Length register and mode latch
    // ------------------------------------------------------------
    logic [LEN_W-1:0] length_r;
    logic [LEN_W-1:0] sw_len_r;
    logic sw_pend_r;
    logic mode_r;
    logic pin_load;
    logic sw_set;

    assign pin_load = adv && !ctl.length_load_n;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            length_r <= LENGTH_RESET;
        end else if (pin_load) begin
            length_r <= ctl.length_in; // [RQ3] [RQ16]
        end else if (adv && sw_pend_r) begin
            length_r <= sw_len_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sw_pend_r <= 1'b0;
        end else if (sw_set) begin
            sw_pend_r <= 1'b1;
        end else if (adv) begin
            sw_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_r <= 1'b0;
        end else if (adv) begin
            mode_r <= ctl.source_select; // [RQ9] [RQ17]
        end
    end

    // ------------------------------------------------------------
    // Delay path
    // ------------------------------------------------------------
    logic [DATA_W-1:0] ram [DEPTH];
    logic [DATA_W-1:0] in_r;
    logic [DATA_W-1:0] out_r;
    logic [DATA_W-1:0] out_nxt;
    logic [LEN_W-1:0] ptr_r;
    logic [LEN_W-1:0] ptr_nxt;
    logic len_load;

    assign len_load = pin_load || (adv && sw_pend_r);
    // Zero length goes straight from the input to the output register
    assign out_nxt = (length_r == '0) ? in_r : ram[ptr_r]; // [RQ4] [RQ5]
    assign ptr_nxt = (ptr_r + 1'b1 >= length_r) ? '0 : ptr_r + 1'b1;

    always_ff @(posedge clk_i) begin
        if (adv && length_r != '0) begin
            ram[ptr_r] <= in_r; // [RQ18]
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_r <= '0;
        end else if (len_load) begin
            ptr_r <= '0;
        end else if (adv) begin
            ptr_r <= ptr_nxt; // [RQ1]
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_r <= '0;
        end else if (adv) begin
            in_r <= mode_r ? out_r : din; // [RQ2] [RQ8] [RQ6]
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_r <= '0;
        end else if (adv) begin
            out_r <= out_nxt; // [RQ7]
        end
    end

    // Output drivers; enable has no path into the line
    assign data_out_o = out_r; // [RQ14]
    assign data_out_oe_o = {DATA_W{!oe_n && !sw_off_r}}; // [RQ13]

    // ------------------------------------------------------------
    // Stream buffer
    // ------------------------------------------------------------
    logic [FCW-1:0] fill;

    pdl_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FDEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(out_nxt),
        .in_valid_i(adv),
        .in_ready_o(fifo_in_ready),
        .out_data_o(stream_data_o),
        .out_valid_o(stream_valid_o),
        .out_ready_i(stream_ready_i),
        .count_o(fill)
    );

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    logic ack_r;
    logic [31:0] rdat_r;
    logic wr_go;

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
    assign sw_set = wr_go && wb_adr_i == REG_LENGTH && wb_sel_i[0];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sw_hold_r <= CTRL_RESET[CTRL_HOLD_BIT];
            sw_off_r <= CTRL_RESET[CTRL_OFF_BIT];
        end else if (wr_go && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            sw_hold_r <= wb_dat_i[CTRL_HOLD_BIT];
            sw_off_r <= wb_dat_i[CTRL_OFF_BIT];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sw_len_r <= LENGTH_RESET;
        end else if (sw_set) begin
            sw_len_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) begin
                sw_len_r[LEN_W-1:8] <= wb_dat_i[LEN_W-1:8];
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdat_r <= '0;
        end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
            unique case (wb_adr_i)
                REG_CTRL: rdat_r <= {30'h0000_0000, sw_off_r, sw_hold_r};
                REG_LENGTH: rdat_r <= {21'h00_0000, length_r};
                REG_STATUS: begin
                    rdat_r <= '0;
                    rdat_r[STAT_MODE_BIT] <= mode_r;
                    rdat_r[STAT_HOLD_BIT] <= hold_r;
                    rdat_r[STAT_EDGE_BIT] <= ctl.edge_select;
                    rdat_r[STAT_PEND_BIT] <= sw_pend_r;
                    rdat_r[STAT_FILL_LSB +: FCW] <= fill;
                end
                default: rdat_r <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_len_capture: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ3]
        pin_load |=> length_r == $past(ctl.length_in))
        else $error("length not captured on load");

    a_hold_freeze: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ11]
        (take && hold_r) |=> $stable(out_r) && $stable(in_r) && $stable(ptr_r))
        else $error("line moved while held");

    a_hold_delay: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ12]
        (take && ctl.clock_hold && !hold_r && !sw_hold_r) |=> hold_r)
        else $error("hold not latched for next edge");

    a_zero_length: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
        (adv && length_r == '0) |=> out_r == $past(in_r))
        else $error("zero length does not bypass memory");

    a_recirc_src: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
        (adv && mode_r) |=> in_r == $past(out_r))
        else $error("recirculate source wrong");

    a_direct_src: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
        (adv && !mode_r) |=> in_r == $past(din))
        else $error("input source wrong");

    a_mode_latch: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ17]
        adv |=> mode_r == $past(ctl.source_select))
        else $error("mode not latched at active edge");

    a_ptr_range: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
        (length_r != '0 && !len_load && adv) |=> ptr_r < length_r || length_r != $past(length_r))
        else $error("memory pointer out of range");

    a_oe_drive: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ13]
        (!oe_n && !sw_off_r) |-> data_out_oe_o == {DATA_W{1'b1}})
        else $error("output not driven while enabled");

    a_edge_pick: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ10]
        tick |-> $past(dclk) != ctl.edge_select)
        else $error("wrong clock edge taken");

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_r |=> !ack_r)
        else $error("ack held longer than one cycle");
endmodule // pdl_delay_line

`default_nettype wire

// *** tb/pdl_far_model.sv ***
`default_nettype none
// ------------------------------------------------------------
// Upstream source and downstream sink
// ------------------------------------------------------------
module pdl_far_model import pdl_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic edge_select_i,
    input wire logic stall_i,
    output logic dev_clk_o,
    output logic [pdl_pkg::DATA_W-1:0] data_o,
    output logic active_o,
    output logic stream_ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] phase_r;
    // Clock stands still while run_i is low; each phase lasts 16 cycles
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_r <= 4'h0;
            dev_clk_o <= 1'b0;
            data_o <= 10'h000;
            active_o <= 1'b0;
        end else begin
            active_o <= 1'b0;
            if (run_i) begin
                phase_r <= phase_r + 4'h1;
            end
            if (run_i && phase_r == 4'hF) begin
                dev_clk_o <= !dev_clk_o;
                active_o <= (!dev_clk_o == edge_select_i);
                // Data moves on the inactive edge, stable around the active one
                if (!dev_clk_o != edge_select_i) begin
                    data_o <= data_o + 10'h001;
                end
            end
        end
    end
    assign stream_ready_o = !stall_i;
endmodule // pdl_far_model
`default_nettype wire

// *** tb/programmable_delay_line_tb.sv ***
`default_nettype none
module programmable_delay_line_tb import pdl_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, dev_clk, oe_n, stream_valid, stream_ready;
    logic run, stall, active;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, rd;
    logic [DATA_W-1:0] data_in, data_out, data_oe, stream_data, e;
    pdl_ctl_t ctl;
    int n_errors = 0;
    int check_count = 0;
    int cycles = 0;

    pdl_delay_line i_pdl_delay_line (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .dev_clk_i(dev_clk),
        .data_in_i(data_in), .ctl_i(ctl), .output_enable_n_i(oe_n), .data_out_o(data_out),
        .data_out_oe_o(data_oe), .stream_data_o(stream_data), .stream_valid_o(stream_valid),
        .stream_ready_i(stream_ready));
    pdl_far_model i_pdl_far_model (.clk_i(clk), .rst_i(rst), .run_i(run),
        .edge_select_i(ctl.edge_select), .stall_i(stall), .dev_clk_o(dev_clk),
        .data_o(data_in), .active_o(active), .stream_ready_o(stream_ready));

    initial begin
        clk = 1'b0;
        forever #25 clk = !clk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic check_data(input logic [9:0] got, input logic [9:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        do @(posedge clk); while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    // Waits for n active edges, ends settled just before the next data change
    task automatic step(input int n);
        repeat (n) begin
            do @(negedge clk); while (active !== 1'b1);
            repeat (12) @(negedge clk);
        end
    endtask
    task automatic load_pin(input logic [10:0] len);
        @(posedge clk);
        ctl.length_in <= len;
        ctl.length_load_n <= 1'b0;
        step(1);
        @(posedge clk);
        ctl.length_load_n <= 1'b1;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {wb_cyc, wb_stb, wb_we, run, stall, oe_n} = 6'h00;
        wb_adr = 8'h00;
        wb_sel = 4'hF;
        wb_dat_w = 32'h0000_0000;
        ctl = '{source_select: 1'b0, edge_select: 1'b1, clock_hold: 1'b0,
                length_load_n: 1'b1, length_in: 11'h000};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wb_xfer(1'b0, REG_CTRL, 32'h0000_0000);
        check_reg(rd, 32'(CTRL_RESET));
        wb_xfer(1'b0, REG_LENGTH, 32'h0000_0000);
        check_reg(rd, 32'(LENGTH_RESET));
        wb_xfer(1'b0, 8'h0C, 32'h0000_0000);
        check_reg(rd, 32'h0000_0000);
        $display("test registers done");
        run <= 1'b1;
        load_pin(11'h000);
        step(4);
        check_data(data_out, data_in - 10'h001);
        check_data(data_oe, 10'h3FF);
        load_pin(11'h041);
        wb_xfer(1'b0, REG_LENGTH, 32'h0000_0000);
        check_reg(rd, 32'h0000_0041);
        step(69);
        check_data(data_out, data_in - 10'h042);
        @(posedge clk);
        oe_n <= 1'b1;
        step(2);
        check_data(data_oe, 10'h000);
        check_data(data_out, data_in - 10'h042);
        @(posedge clk);
        oe_n <= 1'b0;
        $display("test delay done");
        wb_xfer(1'b1, REG_LENGTH, 32'h0000_0003);
        step(8);
        check_data(data_out, data_in - 10'h004);
        @(posedge clk);
        ctl.clock_hold <= 1'b1;
        step(1);
        e = data_in - 10'h004;
        check_data(data_out, e);
        step(3);
        check_data(data_out, e);
        @(posedge clk);
        ctl.clock_hold <= 1'b0;
        step(7);
        check_data(data_out, data_in - 10'h004);
        $display("test hold done");
        @(posedge clk);
        ctl.source_select <= 1'b1;
        e = data_in - 10'h004;
        for (int m = 1; m <= 15; m++) begin
            step(1);
            check_data(data_out, e + 10'((m - 1) % 5) + 10'h001);
        end
        @(posedge clk);
        ctl.source_select <= 1'b0;
        $display("test recirculate done");
        @(posedge clk);
        run <= 1'b0;
        ctl.edge_select <= 1'b0;
        @(posedge clk);
        run <= 1'b1;
        load_pin(11'h000);
        step(4);
        check_data(data_out, data_in - 10'h001);
        $display("test falling edge done");
        load_pin(LEN_MAX);
        step(1283);
        check_data(data_out, data_in - 10'h0FF - 10'h001);
        $display("test longest done");
        wb_xfer(1'b1, REG_CTRL, 32'h0000_0002);
        @(negedge clk);
        check_data(data_oe, 10'h000);
        wb_xfer(1'b0, REG_CTRL, 32'h0000_0000);
        check_reg(rd, 32'h0000_0002);
        wb_xfer(1'b1, REG_CTRL, 32'h0000_0000);
        @(negedge clk);
        check_data(data_oe, 10'h3FF);
        step(1);
        @(posedge clk);
        stall <= 1'b1;
        // First word kept is the output of the next edge, 1280 edges behind the input
        e = data_in - 10'h0FF;
        step(20);
        check_data(stream_data, e);
        check_data(10'(stream_valid), 10'h001);
        @(posedge clk);
        run <= 1'b0;
        wb_xfer(1'b0, REG_STATUS, 32'h0000_0000);
        check_reg(32'(rd[STAT_FILL_LSB +: 5]), 32'(FIFO_DEPTH));
        @(posedge clk);
        stall <= 1'b0;
        repeat (40) @(posedge clk);
        wb_xfer(1'b0, REG_STATUS, 32'h0000_0000);
        check_reg(32'(rd[STAT_FILL_LSB +: 5]), 32'h0000_0000);
        check_data(10'(stream_valid), 10'h000);
        $display("test buffer done");
        finish_test();
    end
endmodule // programmable_delay_line_tb
`default_nettype wire
